/* File: core/itpi_top.sv */
// interval timer port interface: port decode, control word, latch and read-back, three counters
`timescale 1ns/1ps
`default_nettype none
module itpi_top
    import itpi_pkg::*;
#(
    parameter int NUM_CNT = 3,
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host i/o port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // counting
    input wire logic tick,
    input wire logic [NUM_CNT-1:0] gate,
    output logic [NUM_CNT-1:0] cnt_out
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic port_is(input logic [7:0] a, input logic [7:0] p);
        return (a == p) || (a == p + ITPI_ALIAS_OFS);
    endfunction

    wire logic sel_c0 = port_is(io_addr, ITPI_PORT_CNT0);
    wire logic sel_c1 = port_is(io_addr, ITPI_PORT_CNT1);
    wire logic sel_c2 = port_is(io_addr, ITPI_PORT_CNT2);
    wire logic sel_ctl = port_is(io_addr, ITPI_PORT_CTRL);
    wire logic [NUM_CNT-1:0] sel_cnt = {sel_c2, sel_c1, sel_c0};
    wire logic any_sel = sel_ctl || (|sel_cnt);

    // ----------------------------------------
    // control word
    // ----------------------------------------
    wire logic ctl_wr = io_wr && sel_ctl;
    wire logic [1:0] cw_sel = io_wdata[ITPI_SEL_HI:ITPI_SEL_LO];
    wire logic [1:0] cw_rw = io_wdata[ITPI_RW_HI:ITPI_RW_LO];
    wire logic cw_readback = ctl_wr && (cw_sel == ITPI_SEL_READBACK);
    // latch words never touch mode or format of the counter
    wire logic cw_latch = ctl_wr && !cw_readback && (cw_rw == ITPI_RW_LATCH);
    wire logic cw_program = ctl_wr && !cw_readback && (cw_rw != ITPI_RW_LATCH);

    // ----------------------------------------
    // latch and read-back commands
    // ----------------------------------------
    // read-back fields: inverted latch enables and one select bit per counter
    wire logic rb_count = !io_wdata[ITPI_RB_NOCOUNT];
    wire logic rb_stat = !io_wdata[ITPI_RB_NOSTAT];
    wire logic [NUM_CNT-1:0] rb_pick = io_wdata[ITPI_RB_SEL0 +: NUM_CNT];

    // ----------------------------------------
    // per-counter state
    // ----------------------------------------
    logic [2:0] mode [NUM_CNT];
    logic [1:0] rwfmt [NUM_CNT];
    logic [NUM_CNT-1:0] bcd;
    logic [NUM_CNT-1:0] wr_ptr;
    logic [NUM_CNT-1:0] rd_ptr;
    logic [7:0] low_hold [NUM_CNT];
    logic [WIDTH-1:0] latch_val [NUM_CNT];
    logic [NUM_CNT-1:0] cnt_latched;
    logic [NUM_CNT-1:0] stat_latched;
    logic [7:0] stat_val [NUM_CNT];
    logic [NUM_CNT-1:0] load_en;
    logic [WIDTH-1:0] load_value [NUM_CNT];
    logic [WIDTH-1:0] count [NUM_CNT];
    logic [NUM_CNT-1:0] out_level;
    logic [NUM_CNT-1:0] null_count;
    logic [7:0] rd_byte [NUM_CNT];
    logic [NUM_CNT-1:0] prog_en;
    logic [NUM_CNT-1:0] latch_cnt_req;
    logic [NUM_CNT-1:0] latch_st_req;

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : gen_cnt
            wire logic hit = (cw_sel == 2'(g));
            // the counter must see the new mode on the programming edge, not the stale one
            wire logic [2:0] next_mode = prog_en[g] ? io_wdata[ITPI_MODE_HI:ITPI_MODE_LO] : mode[g];
            wire logic wr_here = io_wr && sel_cnt[g];
            wire logic rd_here = io_rd && sel_cnt[g];
            wire logic both = (rwfmt[g] == ITPI_RW_BOTH);
            wire logic [WIDTH-1:0] rd_src = cnt_latched[g] ? latch_val[g] : count[g];
            // a value past the decimal range is clamped so the countdown stays legal
            wire logic [WIDTH-1:0] raw_val = (rwfmt[g] == ITPI_RW_LSB) ? {8'h00, io_wdata} :
                                             (rwfmt[g] == ITPI_RW_MSB) ? {io_wdata, 8'h00} :
                                             {io_wdata, low_hold[g]};
            wire logic [WIDTH-1:0] fit_val = (bcd[g] && raw_val > ITPI_BCD_MAX) ? ITPI_BCD_MAX : raw_val;
            // a two-byte load commits on the high byte only, so half a count never runs
            wire logic wr_done = wr_here && (!both || wr_ptr[g]);
            wire logic rd_done = rd_here && !stat_latched[g] && (!both || rd_ptr[g]);

            // ----------------------------------------
            // command steering
            // ----------------------------------------
            assign prog_en[g] = cw_program && hit;
            assign latch_cnt_req[g] = (cw_latch && hit) || (cw_readback && rb_pick[g] && rb_count);
            assign latch_st_req[g] = cw_readback && rb_pick[g] && rb_stat;
            assign load_en[g] = wr_done;
            assign load_value[g] = fit_val;
            // a pending status byte is served before any count byte
            assign rd_byte[g] = stat_latched[g] ? stat_val[g] :
                                ((rwfmt[g] == ITPI_RW_MSB) || (both && rd_ptr[g])) ? rd_src[15:8] : rd_src[7:0];

            // ----------------------------------------
            // per-counter registers
            // ----------------------------------------
            always_ff @(posedge clk) begin
                if (rst) begin
                    mode[g] <= ITPI_MODE_RST;
                    rwfmt[g] <= ITPI_RW_RST;
                    bcd[g] <= 1'b0;
                    wr_ptr[g] <= 1'b0;
                    rd_ptr[g] <= 1'b0;
                    low_hold[g] <= 8'h00;
                    latch_val[g] <= ITPI_CNT_RST;
                    cnt_latched[g] <= 1'b0;
                    stat_latched[g] <= 1'b0;
                    stat_val[g] <= 8'h00;
                end else if (prog_en[g]) begin
                    mode[g] <= io_wdata[ITPI_MODE_HI:ITPI_MODE_LO];
                    rwfmt[g] <= cw_rw;
                    bcd[g] <= io_wdata[ITPI_BCD_BIT];
                    wr_ptr[g] <= 1'b0;
                    rd_ptr[g] <= 1'b0;
                    cnt_latched[g] <= 1'b0;
                    stat_latched[g] <= 1'b0;
                end else begin
                    if (wr_here && both) begin
                        wr_ptr[g] <= ~wr_ptr[g];
                        low_hold[g] <= io_wdata;
                    end
                    // a status read leaves the byte pointer where it was
                    if (rd_here && stat_latched[g]) begin
                        stat_latched[g] <= 1'b0;
                    end else if (rd_here) begin
                        if (both) begin
                            rd_ptr[g] <= ~rd_ptr[g];
                        end
                        if (rd_done) begin
                            cnt_latched[g] <= 1'b0;
                        end
                    end
                    // new requests are dropped while an earlier snapshot is unread
                    if (latch_cnt_req[g] && !cnt_latched[g]) begin
                        cnt_latched[g] <= 1'b1;
                        latch_val[g] <= count[g];
                    end
                    if (latch_st_req[g] && !stat_latched[g]) begin
                        stat_latched[g] <= 1'b1;
                        stat_val[g] <= {out_level[g], null_count[g], rwfmt[g], mode[g], bcd[g]};
                    end
                end
            end

            // ----------------------------------------
            // counting element
            // ----------------------------------------
            itpi_counter #(
                .WIDTH(WIDTH)
            ) u_counter (
                .clk(clk),
                .rst(rst),
                .program_en(prog_en[g]),
                .mode(next_mode),
                .bcd(bcd[g]),
                .load_en(load_en[g]),
                .load_value(load_value[g]),
                .tick(tick),
                .gate(gate[g]),
                .count(count[g]),
                .out_level(out_level[g]),
                .null_count(null_count[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // read data and outputs
    // ----------------------------------------
    // control port has no read path; it reads as a fixed filler
    wire logic [7:0] next_rdata = sel_c0 ? rd_byte[0] :
                                  sel_c1 ? rd_byte[1] :
                                  sel_c2 ? rd_byte[2] : ITPI_UNDEF_READ;

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
            cnt_out <= '0;
        end else begin
            io_rdata <= io_rd ? next_rdata : 8'h00;
            // any decoded port answers, control reads included
            io_hit <= (io_rd || io_wr) && any_sel;
            cnt_out <= out_level;
        end
    end
endmodule
`default_nettype wire

/* File: core/itpi_pkg.sv */
// package: port map, control word fields and encodings for the interval timer port interface
package itpi_pkg;
    // ----------------------------------------
    // port addresses
    // ----------------------------------------
    localparam logic [7:0] ITPI_PORT_CNT0 = 8'h40;
    localparam logic [7:0] ITPI_PORT_CNT1 = 8'h41;
    localparam logic [7:0] ITPI_PORT_CNT2 = 8'h42;
    localparam logic [7:0] ITPI_PORT_CTRL = 8'h43;
    localparam logic [7:0] ITPI_ALIAS_OFS = 8'h10;
    // ----------------------------------------
    // control word fields
    // ----------------------------------------
    localparam int ITPI_SEL_HI = 7;
    localparam int ITPI_SEL_LO = 6;
    localparam int ITPI_RW_HI = 5;
    localparam int ITPI_RW_LO = 4;
    localparam int ITPI_MODE_HI = 3;
    localparam int ITPI_MODE_LO = 1;
    localparam int ITPI_BCD_BIT = 0;
    localparam int ITPI_RB_NOCOUNT = 5;
    localparam int ITPI_RB_NOSTAT = 4;
    localparam int ITPI_RB_SEL0 = 1;
    localparam logic [1:0] ITPI_SEL_READBACK = 2'h3;
    localparam logic [1:0] ITPI_RW_LATCH = 2'h0;
    localparam logic [1:0] ITPI_RW_LSB = 2'h1;
    localparam logic [1:0] ITPI_RW_MSB = 2'h2;
    localparam logic [1:0] ITPI_RW_BOTH = 2'h3;
    // ----------------------------------------
    // status byte and reset values
    // ----------------------------------------
    localparam int ITPI_ST_OUT = 7;
    localparam int ITPI_ST_NULL = 6;
    localparam logic [7:0] ITPI_UNDEF_READ = 8'h00;
    localparam logic [2:0] ITPI_MODE_RST = 3'h0;
    localparam logic [1:0] ITPI_RW_RST = 2'h0;
    localparam logic [15:0] ITPI_CNT_RST = 16'h0000;
    localparam logic [15:0] ITPI_BCD_MAX = 16'h9999;
    localparam logic [15:0] ITPI_BIN_MAX = 16'hffff;
    // counting phase of one counter
    typedef enum logic [1:0] {
        ITPI_IDLE = 2'b00,
        ITPI_ARMED = 2'b01,
        ITPI_RUN = 2'b11
    } itpi_phase_t;
endpackage

/* File: core/itpi_counter.sv */
// one counting element: decrements on tick, binary or decimal, drives its output
`timescale 1ns/1ps
`default_nettype none
module itpi_counter
    import itpi_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // programming
    input wire logic program_en,
    input wire logic [2:0] mode,
    input wire logic bcd,
    input wire logic load_en,
    input wire logic [WIDTH-1:0] load_value,
    // counting
    input wire logic tick,
    input wire logic gate,
    output logic [WIDTH-1:0] count,
    output logic out_level,
    output logic null_count
);
    itpi_phase_t phase;
    logic [WIDTH-1:0] reload;
    logic programmed;

    // decimal borrow: each zero nibble below the lowest non-zero nibble wraps to nine
    function automatic logic [WIDTH-1:0] dec_bcd(input logic [WIDTH-1:0] v);
        logic [WIDTH-1:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < WIDTH / 4; i++) begin
            if (borrow) begin
                if (v[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    wire logic periodic = (mode[1:0] == 2'b10) || (mode[1:0] == 2'b11);
    wire logic square = (mode[1:0] == 2'b11);
    wire logic at_end = (count == {{(WIDTH-1){1'b0}}, 1'b1}) || (count == '0);
    wire logic [WIDTH-1:0] dec_count = bcd ? dec_bcd(count) : count - {{(WIDTH-1){1'b0}}, 1'b1};

    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= ITPI_IDLE;
            count <= ITPI_CNT_RST;
            reload <= ITPI_CNT_RST;
            out_level <= 1'b0;
            null_count <= 1'b0;
            programmed <= 1'b0;
        end else if (program_en) begin
            phase <= ITPI_IDLE;
            programmed <= 1'b1;
            out_level <= (mode != ITPI_MODE_RST);
            null_count <= 1'b1;
        end else begin
            if (load_en) begin
                reload <= load_value;
                phase <= ITPI_ARMED;
                null_count <= 1'b1;
            end else if (phase == ITPI_ARMED && tick) begin
                count <= reload;
                phase <= ITPI_RUN;
                null_count <= 1'b0;
            end else if (phase == ITPI_RUN && tick && gate) begin
                if (at_end) begin
                    if (periodic) begin
                        count <= reload;
                        out_level <= square ? ~out_level : 1'b1;
                    end else begin
                        count <= dec_count;
                        out_level <= (mode == ITPI_MODE_RST) ? 1'b1 : ~out_level;
                    end
                end else begin
                    count <= dec_count;
                    if (periodic && !square) begin
                        out_level <= 1'b1;
                    end
                end
            end
            if (!programmed) begin
                out_level <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/itpi_top_sva.sv */
// checker: port-level properties of the interval timer port interface
`timescale 1ns/1ps
`default_nettype none
module itpi_top_sva
    import itpi_pkg::*;
#(
    parameter int NUM_CNT = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host i/o port
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_hit,
    // counting
    input wire logic tick,
    input wire logic [NUM_CNT-1:0] gate,
    input wire logic [NUM_CNT-1:0] cnt_out
);
    logic decoded;
    logic ctrl_addr;
    logic prog_wr;
    logic [NUM_CNT-1:0] programmed;
    assign decoded = io_addr inside {[8'h40:8'h43], [8'h50:8'h53]};
    assign ctrl_addr = io_addr == ITPI_PORT_CTRL || io_addr == (ITPI_PORT_CTRL + ITPI_ALIAS_OFS);
    // latch and read-back words leave a counter unprogrammed
    assign prog_wr = io_wr && ctrl_addr && io_wdata[7:6] != 2'h3 && io_wdata[5:4] != 2'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            programmed <= '0;
        end else if (prog_wr) begin
            programmed[io_wdata[7:6]] <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_hit_decoded: assert property ((io_wr || io_rd) && decoded |=> io_hit)
        else $error("no hit after a decoded access");
    chk_hit_spurious: assert property (!((io_wr || io_rd) && decoded) |=> !io_hit)
        else $error("hit without a decoded access");
    chk_ctrl_read_zero: assert property (io_rd && ctrl_addr |=> io_rdata == ITPI_UNDEF_READ)
        else $error("control port read not zero");
    chk_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00)
        else $error("read data without a read");
    chk_out_reset_low: assert property ($fell(rst) |-> cnt_out == '0)
        else $error("counter output high after reset");
    chk_out_unprog: assert property ((cnt_out & ~programmed) == '0)
        else $error("unprogrammed counter output high");
    // cnt_out trails the counting element by one flop, so the old level shows first
    chk_mode0_low: assert property (prog_wr && io_wdata[7:6] == 2'h0 && io_wdata[3:1] == 3'h0 |=> ##1 !cnt_out[0] [*2])
        else $error("mode 0 output not low");
    chk_mode2_high: assert property (prog_wr && io_wdata[7:6] == 2'h1 && io_wdata[2:1] == 2'h2 |-> ##[1:2] cnt_out[1])
        else $error("rate generator output not high");
    cover property (io_wr && ctrl_addr && io_wdata[7:6] == 2'h3);
    cover property (io_wr && ctrl_addr && io_wdata[7:6] != 2'h3 && io_wdata[5:4] == 2'h0);
    cover property (io_rd && decoded && io_addr[4]);
endmodule
bind itpi_top itpi_top_sva #(.NUM_CNT(NUM_CNT)) i_sva (.clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .tick(tick), .gate(gate),
    .cnt_out(cnt_out));
`default_nettype wire

/* File: tb/test_interval_timer_port_interface.sv */
// testbench: host port sequences against the interval timer port interface
`timescale 1ns/1ps
`default_nettype none
module test_interval_timer_port_interface;
    import itpi_pkg::*;
    logic clk, rst, io_wr, io_rd, io_hit, tick;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic [2:0] gate, cnt_out;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    itpi_top i_dut (.clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_hit(io_hit), .tick(tick), .gate(gate), .cnt_out(cnt_out));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a hang would otherwise never reach the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one access, then one idle cycle so strobes never toggle twice in a step
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
                          input logic [7:0] mask);
        logic hit;
        hit = a inside {[8'h40:8'h43], [8'h50:8'h53]};
        io_wr = wr;
        io_rd = ~wr;
        io_addr = a;
        io_wdata = d;
        @(negedge clk);
        check({7'h00, io_hit}, {7'h00, hit});
        if (!wr) begin
            check(io_rdata & mask, e & mask);
        end
        io_wr = 1'b0;
        io_rd = 1'b0;
        @(negedge clk);
        check(io_rdata, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, a, d, 8'h00, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00, e, 8'hff);
    endtask
    task automatic pulse(input logic [2:0] g, input int n);
        gate = g;
        repeat (n) begin
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
            @(negedge clk);
        end
        gate = 3'b000;
    endtask
    initial begin
        rst = 1'b1;
        {io_wr, io_rd, tick, gate, io_addr, io_wdata} = '0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({5'h00, cnt_out}, 8'h00);
        rd(8'h43, ITPI_UNDEF_READ);
        rd(8'h44, 8'h00);
        wr(8'h53, 8'h30);
        check({7'h00, cnt_out[0]}, 8'h00);
        wr(8'h40, 8'h34);
        wr(8'h50, 8'h12);
        wr(8'h43, 8'he2);
        rd(8'h40, 8'h70);
        pulse(3'b001, 1);
        wr(8'h43, 8'hc2);
        rd(8'h40, 8'h30);
        rd(8'h40, 8'h34);
        rd(8'h40, 8'h12);
        wr(8'h43, 8'h00);
        pulse(3'b001, 3);
        wr(8'h43, 8'h00);
        rd(8'h40, 8'h34);
        rd(8'h40, 8'h12);
        wr(8'h43, 8'h00);
        rd(8'h40, 8'h31);
        rd(8'h40, 8'h12);
        wr(8'h43, 8'h54);
        check({7'h00, cnt_out[1]}, 8'h01);
        wr(8'h41, 8'h12);
        pulse(3'b010, 1);
        wr(8'h43, 8'h40);
        rd(8'h51, 8'h12);
        rd(8'h41, 8'h12);
        wr(8'h43, 8'ha4);
        wr(8'h42, 8'h56);
        pulse(3'b100, 1);
        wr(8'h43, 8'h80);
        rd(8'h42, 8'h56);
        for (int m = 0; m < 6; m++) begin
            for (int b = 0; b < 2; b++) begin
                wr(8'h43, {4'hb, m[2:0], b[0]});
                wr(8'h43, 8'he8);
                access(1'b0, 8'h52, 8'h00, {m != 0, 1'b0, 2'h3, m[2:0], b[0]}, 8'hbf);
            end
        end
        // the loop left counter 2 unlatched: the new load must not reach the count before a tick
        wr(8'h42, 8'hab);
        wr(8'h42, 8'hcd);
        rd(8'h42, 8'h00);
        rd(8'h42, 8'h56);
        pulse(3'b100, 1);
        wr(8'h43, 8'h80);
        rd(8'h42, 8'h99);
        rd(8'h42, 8'h99);
        // decimal borrow across two zero digits
        wr(8'h42, 8'h00);
        wr(8'h42, 8'h01);
        pulse(3'b100, 2);
        wr(8'h43, 8'h80);
        rd(8'h42, 8'h99);
        rd(8'h42, 8'h00);
        // a mid-run reset must drop every output, programmed or not
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check({5'h00, cnt_out}, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
